// file: rtl/llrc_act_if.sv
`default_nettype none
// carries action requests and completions between control and pending flags
interface llrc_act_if;
  logic [5:0] set;
  logic [5:0] done;
  logic [5:0] pend;
  modport ctrl (output set, output done, input pend);
  modport seq (input set, input done, output pend);
endinterface : llrc_act_if
`default_nettype wire

// file: rtl/llrc_action_seq.sv
`default_nettype none
// self-clearing action flags: set by a software write of 1, cleared by completion
module llrc_action_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  llrc_act_if.seq act
);
  logic [5:0] pend_q;

  // one flag per action; a new set beats a completion in the same cycle
  for (genvar i = 0; i < 6; i++) begin : g_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_q[i] <= 1'b0;
      end else if (ce) begin
        if (act.set[i]) begin
          pend_q[i] <= 1'b1;
        end else if (act.done[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  assign act.pend = pend_q;
endmodule : llrc_action_seq
`default_nettype wire

// file: rtl/llrc_ctrl.sv
// Notes on behaviour
// - a write of 1 to bit 31 pulses the core soft reset, which leaves registers and timing generator alone.
// - a write of 1 to bit 30 pulses the reset of the timing generator only.
// - a write of 1 to bit 29 pulses the reset of the whole register block.
// - each action bit 31, 30, 29, 26, 25 and 24 falls back to 0 by itself once its action is over.
// - writing 0 to an action bit does nothing at all.
// - a write of 1 to bit 26 aborts the rf test that is running.
// - in continuous transmit the abort waits for the current byte to end, then emits the crc and stops.
// - in continuous receive the abort finishes the packet if an access address was seen, else stops at once, radio off.
// - a write of 1 to bit 25 ends the advertising event in progress.
// - a write of 1 to bit 24 ends the open scan window.
`default_nettype none
module llrc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cont_tx_active,
  input wire logic cont_rx_active,
  input wire logic tx_byte_done,
  input wire logic crc_done,
  input wire logic aa_detected,
  input wire logic rx_pkt_end,
  input wire logic adv_event_active,
  input wire logic scan_window_open,
  output logic core_soft_reset,
  output logic timing_gen_soft_reset,
  output logic reg_block_reset,
  output logic rf_test_a,
  output logic crc_emit,
  output logic radio_off,
  output logic advertising_abort,
  output logic scan_abort
);
  llrc_act_if act ();

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_fire;
  logic [5:0] act_req;
  logic [5:0] done_d;
  logic [2:0] rst_q;
  logic [2:0] rst_cnt_q [3];
  logic [1:0] abort_q;
  logic [1:0] busy_in;
  llrc_pkg::llrc_rf_state_e rf_state_q;
  llrc_pkg::llrc_rf_state_e rf_state_d;
  logic crc_emit_q;
  logic radio_off_q;
  logic rf_test_a_q;

  llrc_action_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .act(act)
  );

  // apb decode; one wait state so every answer comes from a flop
  assign access = psel && penable;
  assign hit_ctrl = (paddr == llrc_pkg::CTRL_ADDR);
  assign hit_stat = (paddr == llrc_pkg::STAT_ADDR);
  assign wr_fire = access && pready_q && pwrite && hit_ctrl && pstrb[3];

  // only ones start actions; a busy action ignores a repeat request
  assign act_req[llrc_pkg::CH_CORE] = pwdata[llrc_pkg::CORE_RST_BIT];
  assign act_req[llrc_pkg::CH_TG] = pwdata[llrc_pkg::TG_RST_BIT];
  assign act_req[llrc_pkg::CH_REG] = pwdata[llrc_pkg::REG_RST_BIT];
  assign act_req[llrc_pkg::CH_RF] = pwdata[llrc_pkg::RF_ABORT_BIT];
  assign act_req[llrc_pkg::CH_ADV] = pwdata[llrc_pkg::ADV_ABORT_BIT];
  assign act_req[llrc_pkg::CH_SCAN] = pwdata[llrc_pkg::SCAN_ABORT_BIT];
  assign act.set = wr_fire ? (act_req & ~act.pend) : 6'h00;
  assign act.done = done_d;

  // bus handshake and error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= access && !pready_q;
      pslverr_q <= access && !pready_q && !hit_ctrl && !hit_stat;
    end
  end

  // read data; reserved and unlisted bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= llrc_pkg::REG_RESET;
    end else if (ce) begin
      if (access && !pready_q && !pwrite && hit_ctrl) begin
        prdata_q <= 32'h0000_0000;
        prdata_q[llrc_pkg::CORE_RST_BIT] <= act.pend[llrc_pkg::CH_CORE];
        prdata_q[llrc_pkg::TG_RST_BIT] <= act.pend[llrc_pkg::CH_TG];
        prdata_q[llrc_pkg::REG_RST_BIT] <= act.pend[llrc_pkg::CH_REG];
        prdata_q[llrc_pkg::RF_ABORT_BIT] <= act.pend[llrc_pkg::CH_RF];
        prdata_q[llrc_pkg::ADV_ABORT_BIT] <= act.pend[llrc_pkg::CH_ADV];
        prdata_q[llrc_pkg::SCAN_ABORT_BIT] <= act.pend[llrc_pkg::CH_SCAN];
      end else if (access && !pready_q && !pwrite && hit_stat) begin
        prdata_q <= {23'h00_0000, rf_state_q, scan_window_open, adv_event_active,
                     aa_detected, cont_rx_active, cont_tx_active, rf_test_a_q};
      end else if (!access) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // three soft reset pulses of fixed length; bit falls with the pulse
  for (genvar k = 0; k < 3; k++) begin : g_rst
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rst_q[k] <= 1'b0;
        rst_cnt_q[k] <= llrc_pkg::CNT_ZERO;
      end else if (ce) begin
        if (act.set[k]) begin
          rst_q[k] <= 1'b1;
          rst_cnt_q[k] <= llrc_pkg::RST_PULSE_CYCLES;
        end else if (rst_q[k] && rst_cnt_q[k] == llrc_pkg::CNT_LAST) begin
          rst_q[k] <= 1'b0;
          rst_cnt_q[k] <= llrc_pkg::CNT_ZERO;
        end else if (rst_q[k]) begin
          rst_cnt_q[k] <= rst_cnt_q[k] - 3'h1;
        end
      end
    end
    assign done_d[k] = rst_q[k] && (rst_cnt_q[k] == llrc_pkg::CNT_LAST);
  end

  // advertising and scan aborts hold until the core drops the activity
  assign busy_in = {scan_window_open, adv_event_active};
  for (genvar j = 0; j < 2; j++) begin : g_abort
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        abort_q[j] <= 1'b0;
      end else if (ce) begin
        if (act.set[llrc_pkg::CH_ADV + j]) begin
          abort_q[j] <= 1'b1;
        end else if (!busy_in[j]) begin
          abort_q[j] <= 1'b0;
        end
      end
    end
    // nothing open means nothing to end, so the bit clears at once
    assign done_d[llrc_pkg::CH_ADV + j] = abort_q[j] && !busy_in[j];
  end

  // rf test abort: pick the stop path from the running test mode
  always_comb begin
    rf_state_d = rf_state_q;
    case (rf_state_q)
      llrc_pkg::RF_IDLE: begin
        if (act.set[llrc_pkg::CH_RF]) begin
          if (cont_tx_active) begin
            rf_state_d = llrc_pkg::RF_TX_BYTE;
          end else if (cont_rx_active && aa_detected) begin
            rf_state_d = llrc_pkg::RF_RX_PKT;
          end else begin
            rf_state_d = llrc_pkg::RF_DONE;
          end
        end
      end
      llrc_pkg::RF_TX_BYTE: begin
        if (tx_byte_done) begin
          rf_state_d = llrc_pkg::RF_TX_CRC;
        end
      end
      llrc_pkg::RF_TX_CRC: begin
        if (crc_done) begin
          rf_state_d = llrc_pkg::RF_DONE;
        end
      end
      llrc_pkg::RF_RX_PKT: begin
        if (rx_pkt_end) begin
          rf_state_d = llrc_pkg::RF_DONE;
        end
      end
      llrc_pkg::RF_DONE: begin
        rf_state_d = llrc_pkg::RF_IDLE;
      end
      default: begin
        rf_state_d = llrc_pkg::RF_IDLE;
      end
    endcase
  end

  assign done_d[llrc_pkg::CH_RF] = (rf_state_q == llrc_pkg::RF_DONE);

  // rf sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_state_q <= llrc_pkg::RF_IDLE;
    end else if (ce) begin
      rf_state_q <= rf_state_d;
    end
  end

  // crc kick, one cycle after the byte in flight has gone out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_emit_q <= 1'b0;
    end else if (ce) begin
      crc_emit_q <= (rf_state_q == llrc_pkg::RF_TX_BYTE) && tx_byte_done;
    end
  end

  // radio off; receive without an access address is cut short, no packet to finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_off_q <= 1'b0;
    end else if (ce) begin
      radio_off_q <= ((rf_state_q == llrc_pkg::RF_IDLE) && act.set[llrc_pkg::CH_RF] && !cont_tx_active
                      && cont_rx_active && !aa_detected)
                     || ((rf_state_q == llrc_pkg::RF_RX_PKT) && rx_pkt_end);
    end
  end

  // abort level to the packet controller, taken from the next state so it rises with the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_test_a_q <= 1'b0;
    end else if (ce) begin
      rf_test_a_q <= (rf_state_d == llrc_pkg::RF_TX_BYTE) || (rf_state_d == llrc_pkg::RF_TX_CRC)
                     || (rf_state_d == llrc_pkg::RF_RX_PKT);
    end
  end

  // every output straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign core_soft_reset = rst_q[llrc_pkg::CH_CORE];
  assign timing_gen_soft_reset = rst_q[llrc_pkg::CH_TG];
  assign reg_block_reset = rst_q[llrc_pkg::CH_REG];
  assign rf_test_a = rf_test_a_q;
  assign crc_emit = crc_emit_q;
  assign radio_off = radio_off_q;
  assign advertising_abort = abort_q[0];
  assign scan_abort = abort_q[1];

  // checks; a frozen clock enable suspends them
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  a_core_rst_pulse: assert property ($rose(core_soft_reset) |-> core_soft_reset[*4] ##1 !core_soft_reset)
    else $error("core soft reset pulse length wrong");

  a_tg_rst_start: assert property (wr_fire && pwdata[30] && !act.pend[1] |=> timing_gen_soft_reset[*4])
    else $error("timing generator reset not pulsed");

  a_reg_rst_only: assert property (wr_fire && pwdata[29] && !pwdata[31] && !core_soft_reset
                                   |=> reg_block_reset && !core_soft_reset)
    else $error("register block reset wrong");

  a_self_clear: assert property ($fell(core_soft_reset) |-> !act.pend[0])
    else $error("core reset bit did not self clear");

  a_zero_no_act: assert property (wr_fire && !pwdata[25] && !act.pend[4] |=> !act.pend[4] && !advertising_abort)
    else $error("write of zero started an action");

  a_tx_crc_after: assert property (rf_state_q == llrc_pkg::RF_TX_BYTE && tx_byte_done
                                   |=> crc_emit ##1 !crc_emit)
    else $error("crc not emitted after byte");

  a_rx_stop_now: assert property (act.set[3] && !cont_tx_active && cont_rx_active && !aa_detected
                                  |=> radio_off && rf_state_q == llrc_pkg::RF_DONE ##1 !act.pend[3])
    else $error("receive abort did not stop at once");

  a_rf_abort_go: assert property (act.set[3] && cont_tx_active |=> rf_test_a && act.pend[3])
    else $error("rf test abort not raised");

  a_adv_hold: assert property (advertising_abort && adv_event_active && !act.set[4]
                               |=> advertising_abort && act.pend[4])
    else $error("advertising abort dropped early");

  a_scan_end: assert property (act.set[5] ##1 !scan_window_open |=> !scan_abort && !act.pend[5])
    else $error("scan abort did not end");

  a_resv_zero: assert property (pready && !pwrite && hit_ctrl |-> prdata[28:27] == 2'b00)
    else $error("reserved bits read non zero");

  // bus answer: one cycle of ready, error only together with it
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  // soft resets: each pulse stays on its own line, each pending bit follows its pulse
  a_core_alone: assert property (wr_fire && pwdata[llrc_pkg::CORE_RST_BIT] && !timing_gen_soft_reset
                                 && !pwdata[llrc_pkg::TG_RST_BIT] && !pwdata[llrc_pkg::REG_RST_BIT]
                                 && !reg_block_reset |=> !timing_gen_soft_reset && !reg_block_reset)
    else $error("core soft reset touched another reset");

  a_tg_alone: assert property (wr_fire && pwdata[llrc_pkg::TG_RST_BIT] && !pwdata[llrc_pkg::CORE_RST_BIT]
                               && !core_soft_reset |=> !core_soft_reset)
    else $error("timing generator reset touched the core reset");

  a_pend_mirror: assert property (act.pend[2:0] == {reg_block_reset, timing_gen_soft_reset, core_soft_reset})
    else $error("reset bit and reset pulse disagree");

  // rf abort: the stop paths wait for their event and keep the bit up meanwhile
  a_rf_busy_pend: assert property (rf_test_a |-> act.pend[llrc_pkg::CH_RF])
    else $error("abort level without pending bit");

  a_tx_wait_byte: assert property (rf_state_q == llrc_pkg::RF_TX_BYTE && !tx_byte_done
                                   |=> rf_state_q == llrc_pkg::RF_TX_BYTE && !crc_emit)
    else $error("crc sent before the byte ended");

  a_rx_pkt_wait: assert property (rf_state_q == llrc_pkg::RF_RX_PKT && !rx_pkt_end
                                  |=> rf_test_a && !radio_off)
    else $error("receive abort cut a detected packet");

  // advertising and scan aborts
  a_adv_end: assert property (act.set[llrc_pkg::CH_ADV] ##1 !adv_event_active
                              |=> !advertising_abort && !act.pend[llrc_pkg::CH_ADV])
    else $error("advertising abort did not end");

  a_scan_hold: assert property (scan_abort && scan_window_open && !act.set[llrc_pkg::CH_SCAN]
                                |=> scan_abort && act.pend[llrc_pkg::CH_SCAN])
    else $error("scan abort dropped early");

  a_zero_scan: assert property (wr_fire && !pwdata[llrc_pkg::SCAN_ABORT_BIT] && !act.pend[llrc_pkg::CH_SCAN]
                                |=> !act.pend[llrc_pkg::CH_SCAN] && !scan_abort)
    else $error("write of zero started a scan abort");

  // coverage of the main scenarios
  c_core_reset: cover property ($rose(core_soft_reset) ##[1:8] !act.pend[0]);
  c_tx_abort: cover property (rf_state_q == llrc_pkg::RF_TX_BYTE ##[1:20] crc_emit);
  c_rx_pkt: cover property (rf_state_q == llrc_pkg::RF_RX_PKT ##[1:20] radio_off);
  c_adv_abort: cover property (advertising_abort ##[1:20] !advertising_abort);
  c_scan_idle: cover property (act.set[llrc_pkg::CH_SCAN] ##1 !scan_window_open);
endmodule : llrc_ctrl
`default_nettype wire

// file: rtl/llrc_pkg.sv
`default_nettype none
package llrc_pkg;
  // register map, byte addresses on the apb bus
  localparam logic [31:0] CTRL_ADDR = 32'h4000_0000;
  localparam logic [31:0] STAT_ADDR = 32'h4000_0004;

  // action bit positions in the control register
  localparam int unsigned CORE_RST_BIT = 31;
  localparam int unsigned TG_RST_BIT = 30;
  localparam int unsigned REG_RST_BIT = 29;
  localparam int unsigned RF_ABORT_BIT = 26;
  localparam int unsigned ADV_ABORT_BIT = 25;
  localparam int unsigned SCAN_ABORT_BIT = 24;

  // action channels, one pending flag each
  localparam int unsigned NUM_ACT = 6;
  localparam int unsigned CH_CORE = 0;
  localparam int unsigned CH_TG = 1;
  localparam int unsigned CH_REG = 2;
  localparam int unsigned CH_RF = 3;
  localparam int unsigned CH_ADV = 4;
  localparam int unsigned CH_SCAN = 5;

  // reset values and pulse length of the three soft resets
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [2:0] RST_PULSE_CYCLES = 3'h4;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_LAST = 3'h1;

  // rf test abort sequencer
  typedef enum logic [2:0] {
    RF_IDLE = 3'b000,
    RF_TX_BYTE = 3'b001,
    RF_TX_CRC = 3'b010,
    RF_RX_PKT = 3'b011,
    RF_DONE = 3'b100
  } llrc_rf_state_e;
endpackage : llrc_pkg
`default_nettype wire

// file: verification/tb_top.sv
`default_nettype none
// one compare: counts the check, reports a mismatch at once
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, cont_tx, cont_rx, byte_done, crc_done, aa_seen, pkt_end, adv_on, scan_on;
  logic [31:0] paddr, pwdata, rd;
  logic [3:0] pstrb;
  logic err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, core_rst, tg_rst, reg_rst, rf_ab, crc_emit, radio_off, adv_ab, scan_ab;
  wire logic [7:0] outs = {core_rst, tg_rst, reg_rst, rf_ab, crc_emit, radio_off, adv_ab, scan_ab};
  int bad_count = 0;
  int n_tests = 0;
  int n;

  llrc_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cont_tx_active(cont_tx), .cont_rx_active(cont_rx), .tx_byte_done(byte_done), .crc_done(crc_done),
    .aa_detected(aa_seen), .rx_pkt_end(pkt_end), .adv_event_active(adv_on), .scan_window_open(scan_on),
    .core_soft_reset(core_rst), .timing_gen_soft_reset(tg_rst), .reg_block_reset(reg_rst), .rf_test_a(rf_ab),
    .crc_emit(crc_emit), .radio_off(radio_off), .advertising_abort(adv_ab), .scan_abort(scan_ab));

  // free-running 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle pulse on a packet-controller input, launched off the edge
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) byte_done <= 1'b1; else if (which == 1) crc_done <= 1'b1; else pkt_end <= 1'b1;
    @(posedge pclk);
    byte_done <= 1'b0;
    crc_done <= 1'b0;
    pkt_end <= 1'b0;
  endtask : pulse

  // counts settled cycles an output stays high; bounded so a stuck flag cannot hang
  task automatic count_high(input int idx);
    #1;
    n = 0;
    while (outs[idx] === 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
      #1;
    end
  endtask : count_high

  // waits, bounded, until an output reaches a level
  task automatic wait_lvl(input int idx, input logic lvl);
    int k;
    k = 0;
    #1; // a one-cycle pulse launched at this edge is visible now
    while (outs[idx] !== lvl && k < 40) begin
      @(posedge pclk);
      #1;
      k++;
    end
    `CHK(outs[idx], lvl)
  endtask : wait_lvl

  task automatic rd_ctrl(input logic [31:0] exp);
    apb(1'b0, llrc_pkg::CTRL_ADDR, 32'h0000_0000, 4'hf);
    `CHK(rd, exp)
  endtask : rd_ctrl

  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, cont_tx, cont_rx, byte_done, crc_done, aa_seen, pkt_end, adv_on, scan_on} = '0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    repeat (16) @(posedge pclk);
    `CHK(outs, 8'h00)
    presetn <= 1'b1;
    rd_ctrl(32'h0000_0000);
    // zeros, reserved bits and a write without the top strobe must all be inert
    apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h0000_0000, 4'hf);
    #1 `CHK(outs, 8'h00)
    apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h18ff_ffff, 4'hf);
    #1 `CHK(outs, 8'h00)
    rd_ctrl(32'h0000_0000);
    apb(1'b1, llrc_pkg::CTRL_ADDR, 32'hff00_0000, 4'h7);
    #1 `CHK(outs, 8'h00)
    apb(1'b1, 32'h4000_0008, 32'hff00_0000, 4'hf);
    `CHK(err, 1'b1)
    #1 `CHK(outs, 8'h00)
    // each soft reset alone, four cycles, then its bit self-clears
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h8000_0000 >> i, 4'hf);
      #1 `CHK(outs, 8'h80 >> i)
      count_high(7 - i);
      `CHK(n, 4)
      rd_ctrl(32'h0000_0000);
    end
    // continuous transmit: abort waits for byte end, then crc, then stops
    cont_tx <= 1'b1;
    apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h0400_0000, 4'hf);
    #1 `CHK(outs, 8'h10)
    rd_ctrl(32'h0400_0000);
    apb(1'b0, llrc_pkg::STAT_ADDR, 32'h0000_0000, 4'hf);
    `CHK(rd[2:0], 3'h3)
    `CHK(crc_emit, 1'b0)
    pulse(0);
    wait_lvl(3, 1'b1);
    count_high(3);
    `CHK(n, 1)
    pulse(1);
    wait_lvl(4, 1'b0);
    cont_tx <= 1'b0;
    rd_ctrl(32'h0000_0000);
    // continuous receive, no access address: radio off straight away
    cont_rx <= 1'b1;
    apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h0400_0000, 4'hf);
    count_high(2);
    `CHK(n, 1)
    rd_ctrl(32'h0000_0000);
    // continuous receive with access address: finish the packet first
    aa_seen <= 1'b1;
    apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h0400_0000, 4'hf);
    repeat (4) @(posedge pclk);
    #1 `CHK(outs[4:2], 3'h4)
    pulse(2);
    wait_lvl(2, 1'b1);
    wait_lvl(4, 1'b0);
    {cont_rx, aa_seen} <= 2'b00;
    rd_ctrl(32'h0000_0000);
    // advertising then scan abort: held while the activity lasts
    for (int i = 0; i < 2; i++) begin
      if (i == 0) adv_on <= 1'b1; else scan_on <= 1'b1;
      apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h0200_0000 >> i, 4'hf);
      #1 `CHK(outs, 8'h02 >> i)
      rd_ctrl(32'h0200_0000 >> i);
      {adv_on, scan_on} <= 2'b00;
      wait_lvl(1 - i, 1'b0);
      rd_ctrl(32'h0000_0000);
    end
    // nothing open: the abort bit is back to zero one edge later
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, llrc_pkg::CTRL_ADDR, 32'h0200_0000 >> i, 4'hf);
      #1 `CHK(outs, 8'h02 >> i)
      wait_lvl(1 - i, 1'b0);
    end
    results();
  end

  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #200us;
    bad_count++;
    results();
  end

  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
endmodule : tb_top
`default_nettype wire
